// [src/tcr_defs.vh]
// Purpose: constants for the thermocouple serial readout
// Assumes: 10 MHz mclk
// Notes: times in their own unit, counts derived from them
`ifndef TCR_DEFS_VH
`define TCR_DEFS_VH
`define TCR_CLK_HZ 10000000
`define TCR_CONV_MS 70
`define TCR_PHASE_CYC ((`TCR_CONV_MS * (`TCR_CLK_HZ / 1000)) / 3)
`define TCR_FRAME_W 32
`define TCR_TC_MSB 31
`define TCR_TC_LSB 18
`define TCR_RES_HI 17
`define TCR_FAULT_BIT 16
`define TCR_CJ_MSB 15
`define TCR_CJ_LSB 4
`define TCR_RES_LO 3
`define TCR_SCV_BIT 2
`define TCR_SCG_BIT 1
`define TCR_OC_BIT 0
`define TCR_TC_RST 14'h0000
`define TCR_CJ_RST 12'h000
`define TCR_PH_CJ 2'h0
`define TCR_PH_TC 2'h1
`define TCR_PH_FLT 2'h2
`endif

// [src/tcr_buf2.v]
// Purpose: two-entry valid/ready buffer for conversion result words
// Assumes: single clock, asynchronous use of the active-low reset copy
// Notes: in_ready drops when both entries hold data
`timescale 1ns/1ps
module tcr_buf2 #(
   parameter W = 32
) (
   input wire clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem_q [0:1];
   reg wp_q;
   reg rp_q;
   reg [1:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rp_q];
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push)
            wp_q <= ~wp_q;
         if (pop)
            rp_q <= ~rp_q;
         if (push && !pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'h1;
      end
   end
   always @(posedge clk) begin
      if (push)
         mem_q[wp_q] <= in_data;
   end
endmodule

// [src/tcr_readout.v]
// Purpose: digital side of a thermocouple converter with serial read-only link
// Assumes: sclk and cs_n are pins, sampled by mclk; adc result is sampled
// Notes: analog front end is outside; adc_done marks a finished phase
//    a finished set is offered to the buffer one cycle after the fault phase
//    the buffer drains only while deselected; in a long read a newer set replaces one still waiting
//    pin edges are seen three mclk late; the host must pace sclk to suit
//
// Summary of operation
// - chip select low enables the link; high ignores serial clock entirely.
// - each conversion period does die, thermocouple and fault phases.
// - conversions run back to back from reset without any host command.
// - results load into frame only while chip select is high.
// - chip select fall drives sign bit D31 onto serial output.
// - thermocouple bits D30..D18 follow msb first after each sclk fall.
// - reference temperature field starts at D15 after fault summary.
// - chip select may rise anytime; transfer ends cleanly, next frame fine.
// - open inputs report D31 zero and D30..D18 all ones.
// - D2, D1, D0 flag short to supply, short to ground, open.
// - D16 set whenever any of the three faults is present.
// - hot junction equals thermocouple delta plus die temperature.
// - straight-line gain per type, no nonlinearity correction.
// - die phase: adc switch open, cold switch closed, ground ref closed, faults open.
// - thermocouple phase: fault and cold switches open, ground ref and adc closed.
// - fault phase: ground ref, adc, cold open; both fault switches closed.
// - reserved bits D17 and D3 always shift out zero.
// - thermocouple field signed 14-bit 0.25C; reference signed 12-bit 0.0625C.
// - full three-phase conversion completes within 100 ms, typically 70.
`timescale 1ns/1ps
`include "tcr_defs.vh"
module tcr_readout #(
   parameter PHASE_CYC = `TCR_PHASE_CYC,
   parameter ADC_W = 16,
   // microvolt per degree times 1000, type K default
   parameter [31:0] GAIN_NV = 32'd41276
) (
   input wire mclk,
   input wire reset_n,
   input wire sclk,
   input wire cs_n,
   output wire sdo_o,
   output wire sdo_oe,
   input wire [ADC_W-1:0] adc_data,
   input wire adc_done,
   input wire short_to_supply_in,
   input wire short_to_ground_in,
   input wire open_circuit_in,
   output reg fault_switch_a,
   output reg fault_switch_b,
   output reg neg_ground_ref_switch,
   output reg adc_input_switch,
   output reg cold_junction_switch,
   output wire adc_start,
   output wire [1:0] phase,
   output wire no_connect_pin
);
   reg rst_s1_q;
   reg rst_q;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_q <= rst_s1_q;
      end
   end
   // release is synchronous so no flop leaves reset on a different edge
   wire rst_n = rst_q;

   // pin synchronisers; first stage read only by second
   reg sclk_s1_q;
   reg sclk_s2_q;
   reg sclk_s3_q;
   reg cs_s1_q;
   reg cs_s2_q;
   reg cs_s3_q;
   wire [2:0] flt_s2_q;
   // adc word is a level that stays put for a whole phase, so two flops do
   reg [ADC_W-1:0] adc_s1_q;
   reg [ADC_W-1:0] adc_s2_q;
   reg done_s1_q;
   reg done_s2_q;
   reg done_s3_q;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         adc_s1_q <= {ADC_W{1'b0}};
         adc_s2_q <= {ADC_W{1'b0}};
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         done_s3_q <= 1'b0;
      end else begin
         sclk_s1_q <= sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         cs_s1_q <= cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         adc_s1_q <= adc_data;
         adc_s2_q <= adc_s1_q;
         done_s1_q <= adc_done;
         done_s2_q <= done_s1_q;
         done_s3_q <= done_s2_q;
      end
   end
   // one two-stage synchroniser per fault level
   wire [2:0] flt_pin = {short_to_supply_in, short_to_ground_in, open_circuit_in};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_flt_sync
         reg s1_q;
         reg s2_q;
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
            end else begin
               s1_q <= flt_pin[gi];
               s2_q <= s1_q;
            end
         end
         assign flt_s2_q[gi] = s2_q;
      end
   endgenerate

   // one edge detector shared by the pin and done paths
   function fell;
      input older;
      input newer;
      begin
         fell = older && !newer;
      end
   endfunction
   // sync delay makes every pin edge visible three mclk late
   wire cs_fall = fell(cs_s3_q, cs_s2_q);
   wire cs_low = !cs_s2_q;
   // serial clock counts only while selected
   wire sclk_fall = fell(sclk_s3_q, sclk_s2_q) && cs_low;
   wire done_rise = fell(!done_s3_q, !done_s2_q);

   // conversion sequencer
   localparam ST_CJ = 2'h0;
   localparam ST_TC = 2'h1;
   localparam ST_FLT = 2'h2;
   // no stall state: a long read only delays the buffer, never a phase
   reg [1:0] st_q;
   reg [1:0] st_d;
   reg [31:0] tmr_q;
   reg [11:0] cj_q;
   reg [13:0] tcd_q;
   reg [2:0] flt_q;
   wire phase_end = (tmr_q == PHASE_CYC - 1) || done_rise;
   assign phase = st_q;
   assign adc_start = (tmr_q == 32'd0);
   always @* begin
      st_d = st_q;
      case (st_q)
         ST_CJ: st_d = ST_TC;
         ST_TC: st_d = ST_FLT;
         ST_FLT: st_d = ST_CJ;
         default: st_d = ST_CJ;
      endcase
   end
   // phase timer bounds the three-phase period near 70 ms
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_CJ;
         tmr_q <= 32'd0;
      end else if (phase_end) begin
         st_q <= st_d;
         tmr_q <= 32'd0;
      end else begin
         tmr_q <= tmr_q + 32'd1;
      end
   end

   // switch steering per phase
   always @* begin
      fault_switch_a = 1'b0;
      fault_switch_b = 1'b0;
      neg_ground_ref_switch = 1'b1;
      adc_input_switch = 1'b0;
      cold_junction_switch = 1'b0;
      case (st_q)
         ST_CJ: cold_junction_switch = 1'b1;
         ST_TC: adc_input_switch = 1'b1;
         ST_FLT: begin
            neg_ground_ref_switch = 1'b0;
            fault_switch_a = 1'b1;
            fault_switch_b = 1'b1;
         end
         default: begin
            neg_ground_ref_switch = 1'b1;
         end
      endcase
   end
   assign no_connect_pin = 1'b0;

   // conversion arithmetic; adc word in 0.0625 degree units of die temperature
   // for the die phase, raw microvolt code for the thermocouple phase
   function [13:0] tc_quarter;
      input [ADC_W-1:0] uv;
      input [11:0] cj;
      reg signed [47:0] num;
      reg signed [47:0] q;
      reg signed [47:0] sum;
      begin
         // linear gain, result in quarter degrees
         num = $signed({{(48-ADC_W){uv[ADC_W-1]}}, uv}) * 48'sd4000;
         q = num / $signed({16'h0000, GAIN_NV});
         // add die temperature, 1/16 to 1/4 degree
         // division truncates toward zero; a fraction of a quarter is lost
         sum = q + ($signed({{36{cj[11]}}, cj}) >>> 2);
         if (sum > 48'sd8191) begin
            // saturate rather than wrap at the 14-bit limits
            tc_quarter = 14'h1fff;
         end else if (sum < -48'sd8192) begin
            tc_quarter = 14'h2000;
         end else begin
            tc_quarter = sum[13:0];
         end
      end
   endfunction

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cj_q <= `TCR_CJ_RST;
         tcd_q <= `TCR_TC_RST;
         flt_q <= 3'h0;
      end else if (phase_end) begin
         case (st_q)
            ST_CJ: cj_q <= adc_s2_q[11:0];
            ST_TC: tcd_q <= tc_quarter(adc_s2_q, cj_q);
            ST_FLT: flt_q <= flt_s2_q;
            default: flt_q <= flt_q;
         endcase
      end
   end

   // completed set goes to the buffer after the fault phase
   reg [31:0] word_new;
   // open inputs read as the most positive value, sign clear
   wire [13:0] tc_field = flt_q[0] ? 14'h1fff : tcd_q;
   // summary flag follows the three individual flags of the same set
   wire fault_any = |flt_q;
   always @* begin
      word_new = 32'h00000000;
      word_new[`TCR_TC_MSB:`TCR_TC_LSB] = tc_field;
      word_new[`TCR_RES_HI] = 1'b0;
      word_new[`TCR_FAULT_BIT] = fault_any;
      word_new[`TCR_CJ_MSB:`TCR_CJ_LSB] = cj_q;
      word_new[`TCR_RES_LO] = 1'b0;
      word_new[`TCR_SCV_BIT] = flt_q[2];
      word_new[`TCR_SCG_BIT] = flt_q[1];
      word_new[`TCR_OC_BIT] = flt_q[0];
   end
   wire buf_in_ready;
   wire buf_out_valid;
   wire [31:0] buf_out_data;
   reg push_q;
   reg load_q;
   reg [31:0] push_word_q;
   // flags land on the phase_end edge, so the word is taken one cycle later
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         load_q <= 1'b0;
         push_q <= 1'b0;
      end else begin
         load_q <= phase_end && (st_q == ST_FLT);
         if (load_q) begin
            push_q <= 1'b1;
         end else if (buf_in_ready) begin
            push_q <= 1'b0;
         end
      end
   end
   // word held steady while offered; a newer set replaces one still waiting
   always @(posedge mclk) begin
      if (load_q) begin
         push_word_q <= word_new;
      end
   end
   // drain only while chip select is high, so a long read stalls
   wire drain = cs_s2_q && cs_s3_q;
   tcr_buf2 #(
      .W(32)
   ) u_buf (
      .clk(mclk),
      .rst_n(rst_n),
      .in_valid(push_q),
      .in_ready(buf_in_ready),
      .in_data(push_word_q),
      .out_valid(buf_out_valid),
      .out_ready(drain),
      .out_data(buf_out_data)
   );

   reg [31:0] frame_q;
   reg [31:0] shift_q;
   reg oe_q;
   // counts serial clock falls; past the last bit the output holds zero
   localparam [5:0] FRAME_BITS = `TCR_FRAME_W;
   reg [5:0] bit_cnt_q;
   // frame_q only moves between reads; shift_q is the copy being read
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         frame_q <= 32'h00000000;
         shift_q <= 32'h00000000;
         oe_q <= 1'b0;
         bit_cnt_q <= 6'h00;
      end else begin
         if (buf_out_valid && drain) begin
            frame_q <= buf_out_data;
         end
         if (cs_fall) begin
            shift_q <= frame_q;
            oe_q <= 1'b1;
            bit_cnt_q <= 6'h00;
         end else if (!cs_low) begin
            // a cut read leaves nothing behind; the next fall reloads
            oe_q <= 1'b0;
         end else if (sclk_fall && (bit_cnt_q != FRAME_BITS)) begin
            shift_q <= {shift_q[30:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 6'h01;
         end
      end
   end
   assign sdo_o = shift_q[31];
   assign sdo_oe = oe_q;
endmodule

// [verification/tcr_readout_properties.sv]
// Purpose: port-level checks of the thermocouple readout
// Assumes: single mclk domain, reset_n active low
// Notes: phase length bound is taken from PHASE_CYC
`timescale 1ns/1ps
module tcr_readout_props #(
   parameter PHASE_CYC = 20
) (
   input wire mclk,
   input wire reset_n,
   input wire cs_n,
   input wire sdo_oe,
   input wire adc_start,
   input wire [1:0] phase,
   input wire fault_switch_a,
   input wire fault_switch_b,
   input wire neg_ground_ref_switch,
   input wire adc_input_switch,
   input wire cold_junction_switch
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire [4:0] sw = {fault_switch_a, fault_switch_b, neg_ground_ref_switch,
      adc_input_switch, cold_junction_switch};
   reg [1:0] ph_q;
   reg [31:0] len_q;
   // counter instead of a long repetition
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ph_q <= 2'h0;
         len_q <= 32'h0;
      end else begin
         ph_q <= phase;
         len_q <= (phase != ph_q) ? 32'h0 : len_q + 32'h1;
      end
   end
   sequence cs_low_held;
      (!cs_n) [*7];
   endsequence
   sequence cs_high_held;
      cs_n [*6];
   endsequence
   oe_drive_a: assert property (cs_low_held |-> sdo_oe)
      else $error("output not driven while selected");
   oe_release_a: assert property (cs_high_held |-> !sdo_oe)
      else $error("output driven while deselected");
   sw_die_a: assert property (phase == 2'h0 |-> sw == 5'h05)
      else $error("die phase switch pattern wrong");
   sw_tc_a: assert property (phase == 2'h1 |-> sw == 5'h06)
      else $error("thermocouple phase switch pattern wrong");
   sw_fault_a: assert property (phase == 2'h2 |-> sw == 5'h18)
      else $error("fault phase switch pattern wrong");
   phase_legal_a: assert property (phase != 2'h3)
      else $error("illegal phase code");
   phase_order_a: assert property ($changed(phase) |->
      phase == (($past(phase) == 2'h2) ? 2'h0 : $past(phase) + 2'h1))
      else $error("phase order wrong");
   phase_start_a: assert property ($changed(phase) |-> adc_start)
      else $error("no start at phase entry");
   phase_len_a: assert property (len_q <= PHASE_CYC + 2)
      else $error("phase lasts too long");
endmodule
bind tcr_readout tcr_readout_props #(.PHASE_CYC(PHASE_CYC)) u_props (.mclk(mclk),
   .reset_n(reset_n), .cs_n(cs_n), .sdo_oe(sdo_oe), .adc_start(adc_start), .phase(phase),
   .fault_switch_a(fault_switch_a), .fault_switch_b(fault_switch_b),
   .neg_ground_ref_switch(neg_ground_ref_switch), .adc_input_switch(adc_input_switch),
   .cold_junction_switch(cold_junction_switch));

// [verification/tcr_host_model.sv]
// Purpose: serial read master on the far side of the readout
// Assumes: sclk period 8 mclk, idles low between frames
// Notes: samples each bit just before the falling sclk edge
`timescale 1ns/1ps
module tcr_host_model (
   input wire mclk,
   input wire sdo,
   output logic cs_n,
   output logic sclk
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic xfer(input int nbits, input int hold, output logic [31:0] d);
      d = 32'h0;
      tick(1);
      cs_n = 1'b0;
      tick(10 + hold);
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b1;
         tick(4);
         d = {d[30:0], sdo};
         sclk = 1'b0;
         tick(4);
      end
      cs_n = 1'b1;
      tick(8);
   endtask
endmodule

// [verification/tb_top.sv]
// Purpose: self-checking bench for the thermocouple readout
// Assumes: die phase reads 25 C, thermocouple phase reads 4128 uV (100 C)
// Notes: short phases so a conversion takes 60 mclk
`timescale 1ns/1ps
module tb_top;
   localparam logic [31:0] GOOD = 32'h07d01900;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic adc_done = 1'b0;
   logic [2:0] flt = 3'h0;
   logic sdo_last = 1'b0;
   logic [31:0] d;
   logic [31:0] exp_t [3] = '{32'h7ffd1901, 32'h07d11902, 32'h07d11904};
   int n_mismatch = 0;
   int num_checks = 0;
   wire sclk, cs_n, sdo_o, sdo_oe, adc_start, no_connect_pin;
   wire fsa, fsb, gnd_sw, adc_sw, cold_sw;
   wire [1:0] phase;
   // released line shows a changing pattern, never the last bit
   wire sdo_w = sdo_oe ? sdo_o : ~sdo_last;
   wire [15:0] adc_data = (phase == 2'h0) ? 16'h0190 : ((phase == 2'h1) ? 16'h1020 : 16'h0000);
   always #50 mclk = ~mclk;
   always @(posedge mclk) sdo_last <= sdo_w;
   tcr_readout #(.PHASE_CYC(20)) u_dut (.mclk(mclk), .reset_n(reset_n), .sclk(sclk),
      .cs_n(cs_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .adc_data(adc_data), .adc_done(adc_done),
      .short_to_supply_in(flt[2]), .short_to_ground_in(flt[1]), .open_circuit_in(flt[0]),
      .fault_switch_a(fsa), .fault_switch_b(fsb), .neg_ground_ref_switch(gnd_sw),
      .adc_input_switch(adc_sw), .cold_junction_switch(cold_sw), .adc_start(adc_start),
      .phase(phase), .no_connect_pin(no_connect_pin));
   tcr_host_model u_host (.mclk(mclk), .sdo(sdo_w), .cs_n(cs_n), .sclk(sclk));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   initial begin
      idle(8);
      reset_n = 1'b1;
      idle(600);
      check("oe_idle", {31'h0, sdo_oe}, 32'h0);
      u_host.xfer(32, 0, d);
      check("frame_good", d, GOOD);
      u_host.xfer(7, 0, d);
      check("frame_cut", d, GOOD >> 25);
      // fault appears mid-read; frame must not move
      fork
         u_host.xfer(32, 400, d);
         begin
            idle(20);
            flt = 3'h1;
         end
      join
      check("frame_frozen", d, GOOD);
      idle(600);
      u_host.xfer(14, 0, d);
      check("tc_only_open", d, 32'h00001fff);
      for (int i = 0; i < 3; i++) begin
         flt = 3'h1 << i;
         idle(600);
         u_host.xfer(32, 0, d);
         check("fault_frame", d, exp_t[i]);
      end
      flt = 3'h0;
      idle(600);
      u_host.xfer(32, 0, d);
      check("fault_cleared", d, GOOD);
      final_report();
   end
   initial begin
      idle(20000);
      n_mismatch++;
      final_report();
   end
endmodule
